// ---- bpsc_map.svh ----
// Purpose: constants for the board power state controller
// Assumes: 20 MHz standby clock
// Notes:   timing counts derived from times in their own units
`ifndef BPSC_MAP_SVH
`define BPSC_MAP_SVH

`define BPSC_CLK_HZ         20000000
`define BPSC_LONG_PRESS_S   4
`define BPSC_LONG_PRESS_CYC (`BPSC_LONG_PRESS_S * `BPSC_CLK_HZ)
`define BPSC_CNT_W          27
`define BPSC_NUM_WAKE       7

// wake source bit positions
`define BPSC_WK_LAN         0
`define BPSC_WK_RING        1
`define BPSC_WK_PME         2
`define BPSC_WK_SWITCH      3
`define BPSC_WK_KBD         4
`define BPSC_WK_RTC         5
`define BPSC_WK_USB         6

// per-source allowed states: bit0 S1, bit1 S3, bit2 S4, bit3 S5 (S5 gated separately)
`define BPSC_ALLOW_LAN      4'h7
`define BPSC_ALLOW_RING     4'h3
`define BPSC_ALLOW_PME      4'h7
`define BPSC_ALLOW_SWITCH   4'hF
`define BPSC_ALLOW_KBD      4'h3
`define BPSC_ALLOW_RTC      4'hF
`define BPSC_ALLOW_USB      4'h3

`endif

// ---- bpsc_partner.sv ----
// Purpose: far-side model: power switch, wake sources, OS software
// Assumes: all lines change just after the falling clock edge
// Notes:   switch line idles high like a pulled-up contact
`timescale 1ns/1ns
`include "bpsc_map.svh"
module bpsc_partner (
    input  wire logic                 i_clk,
    output logic                      o_sw_n,
    output logic [`BPSC_NUM_WAKE-1:0] o_wake,
    output logic                      o_sw_req,
    output bpsc_pkg::bpsc_req_e       o_sw_req_state
);
    import bpsc_pkg::*;

    initial begin
        o_sw_n = 1'b1;
        o_wake = '0;
        o_sw_req = 1'b0;
        o_sw_req_state = BPSC_REQ_S1;
    end

    // hold the switch for cyc cycles, then let the pull-up return
    task automatic press(input int cyc);
        @(negedge i_clk);
        o_sw_n = 1'b0;
        repeat (cyc) @(negedge i_clk);
        o_sw_n = 1'b1;
    endtask

    task automatic wake(input int b);
        @(negedge i_clk);
        o_wake[b] = 1'b1;
        repeat (3) @(negedge i_clk);
        o_wake[b] = 1'b0;
    endtask

    // one-cycle state command; code is scrambled once the strobe drops
    task automatic request(input bpsc_req_e s);
        @(negedge i_clk);
        o_sw_req = 1'b1;
        o_sw_req_state = s;
        @(negedge i_clk);
        o_sw_req = 1'b0;
        o_sw_req_state = bpsc_req_e'(~s);
    endtask
endmodule // bpsc_partner

// ---- bpsc_pkg.sv ----
// Purpose: types for the board power state controller
// Assumes: nothing
// Notes:   one-hot state codes
package bpsc_pkg;
    typedef enum logic [4:0] {
        BPSC_S0 = 5'h01,
        BPSC_S1 = 5'h02,
        BPSC_S3 = 5'h04,
        BPSC_S4 = 5'h08,
        BPSC_S5 = 5'h10
    } bpsc_state_e;

    typedef enum logic [1:0] {
        BPSC_REQ_S1 = 2'h0,
        BPSC_REQ_S3 = 2'h1,
        BPSC_REQ_S4 = 2'h2,
        BPSC_REQ_S5 = 2'h3
    } bpsc_req_e;
endpackage

// ---- bpsc_power_ctrl.sv ----
// Operation
// - short switch press: off to working, working to sleep, sleep to working.
// - switch held past four seconds forces soft-off from working or sleep.
// - switch and RTC alarm wake from S1, S3, S4 and S5.
// - ring, keyboard/mouse and USB wake only from S1 and S3.
// - LAN and PME wake S1, S3, S4; S5 enable resets disabled.
// - with S5 enable set, LAN wake powers on from S5.
// - software commands other transitions from working only; S4 request refused unless context saved.
// - software soft-off command removes power without switch press.
// - telephony ring indication can wake a power-managed system.
// - fans on in S0 and S1, off otherwise.
// - after AC loss restore prior on/off state per option.
//
// Purpose: board power state controller for working, sleep and soft-off
// Assumes: standby clock 20 MHz, i_nrst is the power-on reset
// Notes:   switch and wake pins pass two flip-flops, S5 enable three; software and strap inputs used directly
`timescale 1ns/1ns
`include "bpsc_map.svh"
module bpsc_power_ctrl #(
    parameter logic [`BPSC_CNT_W-1:0] LONG_CYC = `BPSC_CNT_W'(`BPSC_LONG_PRESS_CYC)
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_nrst,
    input  wire logic                      i_sw_n,
    input  wire logic [`BPSC_NUM_WAKE-1:0] i_wake,
    input  wire logic                      i_s5_wake_en,
    input  wire logic                      i_sw_req,
    input  wire bpsc_pkg::bpsc_req_e       i_sw_req_state,
    input  wire logic                      i_ctx_saved,
    input  wire logic                      i_restore_on,
    input  wire logic                      i_last_on,
    output logic                           o_main_pwr,
    output logic                           o_mem_pwr,
    output logic                           o_fan_on,
    output bpsc_pkg::bpsc_state_e          o_state,
    output logic                           o_sleep_btn,
    output logic                           o_woke,
    output logic                           o_req_refused
);
    import bpsc_pkg::*;

    localparam logic [`BPSC_NUM_WAKE-1:0] WK_ONE = `BPSC_NUM_WAKE'(1);

    // synchronisers: meta stage read only by the second stage
    logic [`BPSC_NUM_WAKE+1:0] meta_reg;
    logic [`BPSC_NUM_WAKE+1:0] sync_reg;
    logic                      s5en_reg;
    logic                      strap_done_reg;
    bpsc_state_e               state_reg;
    bpsc_state_e               state_next;

    wire [`BPSC_NUM_WAKE+1:0] raw_in = {i_s5_wake_en, !i_sw_n, i_wake};

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= raw_in;
            sync_reg <= meta_reg;
        end
    end

    wire                      sw_pressed = sync_reg[`BPSC_NUM_WAKE];
    wire [`BPSC_NUM_WAKE-1:0] wake_s     = sync_reg[`BPSC_NUM_WAKE-1:0];

    // s5 wake enable comes up disabled and follows setup thereafter
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s5en_reg <= 1'b0;
        end else begin
            s5en_reg <= sync_reg[`BPSC_NUM_WAKE+1];
        end
    end

    wire press_short;
    wire press_long;

    bpsc_press_timer #(
        .LONG_CYC (LONG_CYC)
    ) u_press (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_sw    (sw_pressed),
        .o_short (press_short),
        .o_long  (press_long)
    );

    // per-source gating by current sleep state
    localparam logic [4*`BPSC_NUM_WAKE-1:0] ALLOW = {
        `BPSC_ALLOW_USB, `BPSC_ALLOW_RTC, `BPSC_ALLOW_KBD, `BPSC_ALLOW_SWITCH,
        `BPSC_ALLOW_PME, `BPSC_ALLOW_RING, `BPSC_ALLOW_LAN};

    wire [3:0] st_sel = {state_reg == BPSC_S5, state_reg == BPSC_S4,
                         state_reg == BPSC_S3, state_reg == BPSC_S1};
    logic [`BPSC_NUM_WAKE-1:0] wake_ok;

    genvar g;
    generate
        for (g = 0; g < `BPSC_NUM_WAKE; g++) begin : g_gate
            assign wake_ok[g] = wake_s[g] && |(ALLOW[4*g +: 4] & st_sel);
        end
    endgenerate

    wire lan_s5   = wake_s[`BPSC_WK_LAN] && s5en_reg && (state_reg == BPSC_S5);
    wire pme_s5   = wake_s[`BPSC_WK_PME] && s5en_reg && (state_reg == BPSC_S5);
    wire sleeping = (state_reg != BPSC_S0);
    wire wake_any = sleeping && (|wake_ok || lan_s5 || pme_s5);
    wire s4_ok    = (i_sw_req_state != BPSC_REQ_S4) || i_ctx_saved;
    wire sw_go    = i_sw_req && (state_reg == BPSC_S0) && s4_ok;
    wire sw_off   = i_sw_req && (i_sw_req_state == BPSC_REQ_S5);
    wire refuse   = i_sw_req && !sw_go && !sw_off;

    always_comb begin
        state_next = state_reg;
        if (press_long) begin
            state_next = BPSC_S5;
        end else if (sw_off) begin
            state_next = BPSC_S5;
        end else if (press_short) begin
            state_next = sleeping ? BPSC_S0 : BPSC_S1;
        end else if (wake_any) begin
            state_next = BPSC_S0;
        end else if (sw_go) begin
            unique case (i_sw_req_state)
                BPSC_REQ_S1: state_next = BPSC_S1;
                BPSC_REQ_S3: state_next = BPSC_S3;
                BPSC_REQ_S4: state_next = BPSC_S4;
                BPSC_REQ_S5: state_next = BPSC_S5;
            endcase
        end
    end

    // state after AC return is caught one clock after reset release
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg      <= BPSC_S5;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            state_reg      <= (i_restore_on && i_last_on) ? BPSC_S0 : BPSC_S5;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_main_pwr    <= 1'b0;
            o_mem_pwr     <= 1'b0;
            o_fan_on      <= 1'b0;
            o_state       <= BPSC_S5;
            o_sleep_btn   <= 1'b0;
            o_woke        <= 1'b0;
            o_req_refused <= 1'b0;
        end else begin
            o_main_pwr    <= (state_reg == BPSC_S0) || (state_reg == BPSC_S1);
            o_mem_pwr     <= (state_reg != BPSC_S4) && (state_reg != BPSC_S5);
            o_fan_on      <= (state_reg == BPSC_S0) || (state_reg == BPSC_S1);
            o_state       <= state_reg;
            o_sleep_btn   <= press_short && !sleeping && strap_done_reg;
            o_woke        <= wake_any && !press_long && !sw_off && !press_short;
            o_req_refused <= refuse && strap_done_reg;
        end
    end

    fan_state_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_fan_on == ((o_state == BPSC_S0) || (o_state == BPSC_S1)))
        else $error("fan does not follow state");
    long_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (strap_done_reg && press_long) |=> state_reg == BPSC_S5)
        else $error("long press did not force soft-off");
    short_on_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (strap_done_reg && press_short && !press_long && !sw_off && sleeping)
        |=> state_reg == BPSC_S0)
        else $error("short press did not wake");
    short_sleep_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (strap_done_reg && press_short && !sw_off && !sleeping) |=> state_reg == BPSC_S1)
        else $error("short press did not sleep");
    ring_s4_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state_reg == BPSC_S4) |-> !wake_ok[`BPSC_WK_RING] && !wake_ok[`BPSC_WK_USB])
        else $error("ring or usb woke from deep state");
    rtc_wake_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (strap_done_reg && sleeping && wake_s[`BPSC_WK_RTC] && !i_sw_req
         && !press_long && !press_short) |=> state_reg == BPSC_S0)
        else $error("rtc alarm did not wake");
    lan_s5_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state_reg == BPSC_S5 && !s5en_reg && wake_s == (WK_ONE << `BPSC_WK_LAN)
         && !press_short && !press_long && !i_sw_req && strap_done_reg)
        |=> state_reg == BPSC_S5)
        else $error("lan woke from S5 while disabled");
    lan_on_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (strap_done_reg && lan_s5 && !press_long && !i_sw_req) |=> state_reg == BPSC_S0)
        else $error("lan did not wake from S5");
    soft_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (strap_done_reg && sw_off) |=> state_reg == BPSC_S5 ##1 !o_main_pwr)
        else $error("soft-off command ignored");
    s4_ctx_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (strap_done_reg && state_reg == BPSC_S0 && i_sw_req && i_sw_req_state == BPSC_REQ_S4
         && !i_ctx_saved && !press_long && !press_short) |=> state_reg == BPSC_S0)
        else $error("S4 entered without saved context");
    awake_ign_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (strap_done_reg && state_reg == BPSC_S0 && |wake_s && !i_sw_req
         && !press_long && !press_short) |=> state_reg == BPSC_S0 && !o_woke)
        else $error("wake taken while working");
    s4_refuse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (strap_done_reg && i_sw_req && i_sw_req_state == BPSC_REQ_S4 && !i_ctx_saved)
        |=> o_req_refused)
        else $error("S4 request without context not refused");
    s4_rails_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (strap_done_reg && state_reg == BPSC_S4) |=> !o_mem_pwr && !o_main_pwr)
        else $error("rails powered in S4");

    cov_sleep_c: cover property (@(posedge i_clk) state_reg == BPSC_S1);
    cov_s3_wake_c: cover property (@(posedge i_clk)
        state_reg == BPSC_S3 ##1 state_reg == BPSC_S0);
    cov_long_c: cover property (@(posedge i_clk) press_long);
    cov_lan_s5_c: cover property (@(posedge i_clk) lan_s5);
    cov_refuse_c: cover property (@(posedge i_clk) o_req_refused);
endmodule // bpsc_power_ctrl

// ---- bpsc_power_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the power state controller
// Assumes: long press threshold shortened to keep the run brief
// Notes:   pulse outputs are counted while they stand
`timescale 1ns/1ns
`include "bpsc_map.svh"
module bpsc_power_ctrl_tb_top;
    import bpsc_pkg::*;
    localparam int LONG = 20;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        s5_en = 1'b0;
    logic        ctx = 1'b0;
    logic        rst_on = 1'b0;
    logic        last_on = 1'b0;
    logic        sw_n, sw_req, main_pwr, mem_pwr, fan, slp, woke, refused;
    logic [6:0]  wake;
    bpsc_req_e   req_st;
    bpsc_state_e st;
    int          woke_cnt = 0;
    int          ref_cnt = 0;
    int          slp_cnt = 0;
    int          err_total = 0;
    int          n_tests = 0;

    always #25 clk = ~clk;

    always @(posedge clk) begin
        if (woke === 1'b1) woke_cnt <= woke_cnt + 1;
        if (refused === 1'b1) ref_cnt <= ref_cnt + 1;
        if (slp === 1'b1) slp_cnt <= slp_cnt + 1;
    end

    bpsc_partner i_partner (.i_clk(clk), .o_sw_n(sw_n), .o_wake(wake), .o_sw_req(sw_req),
        .o_sw_req_state(req_st));

    bpsc_power_ctrl #(.LONG_CYC(`BPSC_CNT_W'(LONG))) i_dut (
        .i_clk(clk), .i_nrst(nrst), .i_sw_n(sw_n), .i_wake(wake), .i_s5_wake_en(s5_en),
        .i_sw_req(sw_req), .i_sw_req_state(req_st), .i_ctx_saved(ctx),
        .i_restore_on(rst_on), .i_last_on(last_on), .o_main_pwr(main_pwr),
        .o_mem_pwr(mem_pwr), .o_fan_on(fan), .o_state(st), .o_sleep_btn(slp),
        .o_woke(woke), .o_req_refused(refused));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // settle, then compare state with the rails it implies
    task automatic look(input logic [4:0] s);
        repeat (8) @(negedge clk);
        chk({st, main_pwr, mem_pwr, fan}, {s, |s[1:0], |s[2:0], |s[1:0]});
    endtask

    task automatic t_switch;
        int s0;
        s0 = slp_cnt;
        look(BPSC_S5);
        i_partner.press(5);
        look(BPSC_S0);
        chk(8'(slp_cnt - s0), 8'h00);
        i_partner.press(5);
        look(BPSC_S1);
        chk(8'(slp_cnt - s0), 8'h01);
        i_partner.press(5);
        look(BPSC_S0);
        chk(8'(slp_cnt - s0), 8'h01);
    endtask

    task automatic t_ring;
        int w0;
        i_partner.request(BPSC_REQ_S3);
        look(BPSC_S3);
        w0 = woke_cnt;
        i_partner.wake(`BPSC_WK_RING);
        look(BPSC_S0);
        chk(8'(woke_cnt - w0), 8'h01);
    endtask

    task automatic t_s4;
        int r0;
        r0 = ref_cnt;
        i_partner.request(BPSC_REQ_S4);
        look(BPSC_S0);
        chk(8'(ref_cnt - r0), 8'h01);
        ctx = 1'b1;
        i_partner.request(BPSC_REQ_S4);
        look(BPSC_S4);
        i_partner.wake(`BPSC_WK_USB);
        look(BPSC_S4);
        i_partner.wake(`BPSC_WK_PME);
        look(BPSC_S0);
    endtask

    task automatic t_s5;
        i_partner.request(BPSC_REQ_S5);
        look(BPSC_S5);
        i_partner.wake(`BPSC_WK_LAN);
        look(BPSC_S5);
        s5_en = 1'b1;
        i_partner.wake(`BPSC_WK_LAN);
        look(BPSC_S0);
        i_partner.request(BPSC_REQ_S5);
        look(BPSC_S5);
        i_partner.wake(`BPSC_WK_RTC);
        look(BPSC_S0);
    endtask

    task automatic t_s0_long;
        int w0;
        w0 = woke_cnt;
        i_partner.wake(`BPSC_WK_SWITCH);
        look(BPSC_S0);
        chk(8'(woke_cnt - w0), 8'h00);
        i_partner.request(BPSC_REQ_S1);
        look(BPSC_S1);
        i_partner.wake(`BPSC_WK_KBD);
        look(BPSC_S0);
        i_partner.request(BPSC_REQ_S1);
        look(BPSC_S1);
        i_partner.press(LONG + 10);
        look(BPSC_S5);
    endtask

    task automatic t_restore;
        nrst = 1'b0;
        rst_on = 1'b1;
        last_on = 1'b1;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        look(BPSC_S0);
    endtask

    task automatic finish_test;
        $display("mismatches %0d of %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #(50 * 5000);
        err_total++;
        finish_test();
    end

    initial begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        t_switch();
        t_ring();
        t_s4();
        t_s5();
        t_s0_long();
        t_restore();
        finish_test();
    end
endmodule // bpsc_power_ctrl_tb_top

// ---- bpsc_press_timer.sv ----
// Purpose: measures power switch presses, classifies short and long
// Assumes: i_sw already synchronised, active high while pressed
// Notes:   long pulse fires once when threshold is reached while held
`timescale 1ns/1ns
`include "bpsc_map.svh"
module bpsc_press_timer #(
    parameter logic [`BPSC_CNT_W-1:0] LONG_CYC = `BPSC_CNT_W'(`BPSC_LONG_PRESS_CYC)
) (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_sw,
    output logic      o_short,
    output logic      o_long
);
    logic [`BPSC_CNT_W-1:0] cnt_reg;
    logic                   sw_d_reg;
    logic                   done_reg;

    wire press_start = i_sw && !sw_d_reg;
    wire release_ev  = !i_sw && sw_d_reg;
    // stale count from an earlier press must not fire on a new press
    wire at_limit    = i_sw && !press_start && !done_reg
                       && (cnt_reg == LONG_CYC - `BPSC_CNT_W'(1));

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg  <= '0;
            sw_d_reg <= 1'b0;
            done_reg <= 1'b0;
            o_short  <= 1'b0;
            o_long   <= 1'b0;
        end else begin
            sw_d_reg <= i_sw;
            // restart on each new press
            if (press_start) begin
                cnt_reg  <= `BPSC_CNT_W'(1);
                done_reg <= 1'b0;
            end else if (i_sw && !done_reg) begin
                cnt_reg <= cnt_reg + `BPSC_CNT_W'(1);
            end
            if (at_limit) begin
                done_reg <= 1'b1;
            end
            o_long  <= at_limit;
            o_short <= release_ev && !done_reg;
        end
    end

    press_long_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        at_limit |=> o_long && !o_short)
        else $error("long press not flagged");
    press_short_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (release_ev && done_reg) |=> !o_short)
        else $error("short reported after long press");
endmodule // bpsc_press_timer
